/* rtl/cache_policy_pkg.sv */
// constants shared by the cache policy controller and the tag sram model
// assumes one 10 MHz clock, synchronous active-high reset
package cache_policy_pkg;

    // register offsets in the extended setup space
    localparam logic [11:0] MEM_SETUP_OFFSET   = 12'h180;
    localparam logic [11:0] BANK0_WINDOW_OFFSET = 12'h184;
    localparam logic [11:0] BANK1_WINDOW_OFFSET = 12'h185;
    localparam logic [11:0] BANK2_WINDOW_OFFSET = 12'h186;
    localparam logic [11:0] BANK3_WINDOW_OFFSET = 12'h187;

    // memory setup register fields
    localparam int CACHE_NORMAL_BIT = 0;
    localparam logic [7:0] MEM_SETUP_RESET    = 8'h00;
    localparam logic [7:0] BANK_WINDOW_RESET  = 8'h00;

    // address layout for a 256 kbyte cache over 16 mbyte of dram
    localparam int INDEX_LO = 2;
    localparam int INDEX_HI = 17;
    localparam int TAG_LO   = 18;
    localparam int TAG_HI   = 23;
    localparam int INDEX_W  = INDEX_HI - INDEX_LO + 1;
    localparam int TAG_W    = TAG_HI - TAG_LO + 1;

    // each bank window is in 1 mbyte units: bank n covers window..window+size-1
    localparam int WINDOW_SHIFT = 20;
    localparam logic [7:0] BANK_SPAN_MB = 8'h04;

    typedef enum logic [2:0] {
        CYC_CPU     = 3'h1,
        CYC_DMA     = 3'h2,
        CYC_CHANNEL = 3'h4
    } master_t;

endpackage

/* rtl/tag_compare.sv */
// bit-for-bit compare of stored tag against address tag
// assumes stored tag is valid in the cycle it is presented
`timescale 1ns/1ps
module tag_compare #(
    parameter int TAG_W = 6
) (
    input  wire logic [TAG_W-1:0] stored_tag_i,
    input  wire logic [TAG_W-1:0] addr_tag_i,
    output logic                  hit_o
);
    // any single differing bit makes a miss
    assign hit_o = (stored_tag_i == addr_tag_i);
endmodule

/* rtl/cache_policy.sv */
// per-cycle cache policy decision for a direct-mapped write-through cache
// assumes one request per cycle, request inputs synchronous to clk_i, tag sram read combinationally
// Operation
// - only dram inside enabled bank windows is cached; io, channel slave and other cycles bypass.
// - cpu read hit returns cache data; a miss reads dram and refills line and tag.
// - cpu or dma write hit writes cache and dram; a miss writes dram only with no allocation.
// - dma read hit is served by cache; a miss reads dram and leaves cache and tag alone.
// - channel master reads always come from dram; writes go to dram and also cache on hit.
// - reset leaves the cache in forced-miss mode since tags start invalid.
// - forced-miss sends all accesses to dram; cpu reads still refill, writes leave the cache.
// - address bits 2..17 index the line and bits 18..23 form the tag.
// - hit only when every stored tag bit matches the address tag.
// - write hits update only enabled byte lanes; a refill replaces all four bytes.
`timescale 1ns/1ps
module cache_policy (
    input  wire logic                                  clk_i,
    input  wire logic                                  reset_i,
    // processor side request
    input  wire logic                                  req_valid_i,
    input  wire logic [2:0]                            req_master_i,
    input  wire logic                                  req_mem_i,
    input  wire logic                                  req_write_i,
    input  wire logic [31:0]                           req_addr_i,
    input  wire logic [3:0]                            req_be_i,
    // setup register port
    input  wire logic                                  reg_wr_i,
    input  wire logic                                  reg_rd_i,
    input  wire logic [11:0]                           reg_addr_i,
    input  wire logic [7:0]                            reg_wdata_i,
    output logic      [7:0]                            reg_rdata_o,
    // external tag sram
    input  wire logic [cache_policy_pkg::TAG_W-1:0]    tag_rdata_i,
    output logic      [cache_policy_pkg::INDEX_W-1:0]  line_index_o,
    output logic      [cache_policy_pkg::TAG_W-1:0]    tag_wdata_o,
    output logic                                       tag_wr_o,
    // data sram and dram controls
    output logic      [3:0]                            cache_wr_o,
    output logic                                       cache_rd_o,
    output logic                                       dram_rd_o,
    output logic      [3:0]                            dram_wr_o,
    output logic                                       hit_o,
    output logic                                       forced_miss_o
);

    logic [7:0] setup_q;
    logic [7:0] window_q [4];
    logic       tag_match;
    logic       in_window;
    logic [3:0] bank_hit;
    logic [7:0] addr_mb;

    // register access
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            setup_q <= cache_policy_pkg::MEM_SETUP_RESET;
        end else if (reg_wr_i && reg_addr_i == cache_policy_pkg::MEM_SETUP_OFFSET) begin
            setup_q <= reg_wdata_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bank
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    window_q[g] <= cache_policy_pkg::BANK_WINDOW_RESET;
                end else if (reg_wr_i &&
                             reg_addr_i == cache_policy_pkg::BANK0_WINDOW_OFFSET + 12'(g)) begin
                    window_q[g] <= reg_wdata_i;
                end
            end
            // bank covers a fixed span of mbytes from its window base
            assign bank_hit[g] = (window_q[g] != 8'h00 || g == 0) &&
                                 addr_mb >= window_q[g] &&
                                 {1'b0, addr_mb} < {1'b0, window_q[g]} + 9'(cache_policy_pkg::BANK_SPAN_MB);
        end
    endgenerate

    assign addr_mb = req_addr_i[cache_policy_pkg::WINDOW_SHIFT +: 8];

    wire [cache_policy_pkg::INDEX_W-1:0] addr_index =
        req_addr_i[cache_policy_pkg::INDEX_HI:cache_policy_pkg::INDEX_LO];
    wire [cache_policy_pkg::TAG_W-1:0]   addr_tag   =
        req_addr_i[cache_policy_pkg::TAG_HI:cache_policy_pkg::TAG_LO];

    wire [7:0] reg_rd_mux =
        (reg_addr_i == cache_policy_pkg::MEM_SETUP_OFFSET)    ? setup_q :
        (reg_addr_i == cache_policy_pkg::BANK0_WINDOW_OFFSET) ? window_q[0] :
        (reg_addr_i == cache_policy_pkg::BANK1_WINDOW_OFFSET) ? window_q[1] :
        (reg_addr_i == cache_policy_pkg::BANK2_WINDOW_OFFSET) ? window_q[2] :
        (reg_addr_i == cache_policy_pkg::BANK3_WINDOW_OFFSET) ? window_q[3] : 8'h00;

    tag_compare #(
        .TAG_W(cache_policy_pkg::TAG_W)
    ) u_cmp (
        .stored_tag_i (tag_rdata_i),
        .addr_tag_i   (addr_tag),
        .hit_o        (tag_match)
    );

    // decision
    wire normal     = setup_q[cache_policy_pkg::CACHE_NORMAL_BIT];
    assign in_window = |bank_hit;
    wire cacheable  = req_valid_i && req_mem_i && in_window;
    wire is_cpu     = req_master_i == 3'(cache_policy_pkg::CYC_CPU);
    wire is_dma     = req_master_i == 3'(cache_policy_pkg::CYC_DMA);
    wire is_chan    = req_master_i == 3'(cache_policy_pkg::CYC_CHANNEL);
    wire hit        = cacheable && normal && tag_match;
    wire rd         = req_valid_i && !req_write_i;
    wire wr         = req_valid_i && req_write_i;

    wire read_cache = rd && hit && (is_cpu || is_dma);
    wire refill     = rd && cacheable && is_cpu && !hit;
    wire wr_hit     = wr && hit && (is_cpu || is_dma || is_chan);
    wire [3:0] cwr_d = refill ? 4'hf : (wr_hit ? req_be_i : 4'h0);
    wire       drd_d = rd && req_mem_i && !read_cache;
    wire [3:0] dwr_d = (wr && req_mem_i) ? req_be_i : 4'h0;

    // register read data, zero when idle or unmapped
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_rd_i ? reg_rd_mux : 8'h00;
        end
    end

    // sram index and tag follow every cycle's address
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            line_index_o <= '0;
            tag_wdata_o  <= '0;
        end else begin
            line_index_o <= addr_index;
            tag_wdata_o  <= addr_tag;
        end
    end

    // strobes and status
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tag_wr_o      <= 1'b0;
            cache_wr_o    <= 4'h0;
            cache_rd_o    <= 1'b0;
            dram_rd_o     <= 1'b0;
            dram_wr_o     <= 4'h0;
            hit_o         <= 1'b0;
            forced_miss_o <= 1'b1;
        end else begin
            tag_wr_o      <= refill;
            cache_wr_o    <= cwr_d;
            cache_rd_o    <= read_cache;
            dram_rd_o     <= drd_d;
            dram_wr_o     <= dwr_d;
            hit_o         <= hit;
            forced_miss_o <= !normal;
        end
    end

    // checks
    reset_forced_a: assert property (@(posedge clk_i) $past(reset_i) |-> forced_miss_o)
        else $error("not in forced-miss after reset");
    mode_track_a: assert property (@(posedge clk_i) disable iff (reset_i)
        1'b1 |=> forced_miss_o == !$past(normal))
        else $error("forced-miss flag does not follow mode");
    io_bypass_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (req_valid_i && !req_mem_i) |=> (cache_wr_o == 4'h0 && !cache_rd_o && !tag_wr_o))
        else $error("io cycle touched cache");
    io_dram_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (req_valid_i && !req_mem_i) |=> !dram_rd_o && dram_wr_o == 4'h0)
        else $error("io cycle touched dram");
    window_bypass_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (req_valid_i && !in_window) |=> (!cache_rd_o && !tag_wr_o && cache_wr_o == 4'h0))
        else $error("out-of-window cycle touched cache");
    forced_dram_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!normal && req_valid_i && req_mem_i) |=> !cache_rd_o && !hit_o)
        else $error("forced-miss served from cache");
    forced_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!normal && wr) |=> (cache_wr_o == 4'h0 && !tag_wr_o))
        else $error("forced-miss write touched cache");
    chan_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd && is_chan && req_mem_i) |=> dram_rd_o && !cache_rd_o && !tag_wr_o)
        else $error("channel read not from dram");
    chan_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr && is_chan && hit) |=> cache_wr_o == $past(req_be_i) && dram_wr_o == $past(req_be_i))
        else $error("channel write hit missed cache or dram");
    write_noalloc_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr && !hit) |=> (cache_wr_o == 4'h0 && !tag_wr_o))
        else $error("write miss allocated");
    dram_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr && req_mem_i) |=> dram_wr_o == $past(req_be_i))
        else $error("memory write did not reach dram");
    dma_miss_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd && is_dma && !hit) |=> !tag_wr_o && cache_wr_o == 4'h0)
        else $error("dma miss updated cache");
    dma_hit_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd && is_dma && hit) |=> cache_rd_o && !dram_rd_o)
        else $error("dma read hit not from cache");
    refill_full_a: assert property (@(posedge clk_i) disable iff (reset_i)
        tag_wr_o |-> cache_wr_o == 4'hf && dram_rd_o)
        else $error("refill strobes incomplete");
    tag_out_a: assert property (@(posedge clk_i) disable iff (reset_i)
        tag_wr_o |-> tag_wdata_o == $past(addr_tag))
        else $error("refill tag not from address");
    cpu_hit_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd && is_cpu && hit) |=> cache_rd_o && !dram_rd_o)
        else $error("cpu read hit not from cache");
    cpu_refill_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd && is_cpu && cacheable && !hit) |=> tag_wr_o && dram_rd_o && !cache_rd_o)
        else $error("cpu read miss did not refill");
    write_lanes_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_hit) |=> cache_wr_o == $past(req_be_i))
        else $error("write hit lanes wrong");
    lane_match_a: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_hit |=> dram_wr_o == cache_wr_o)
        else $error("write hit lanes differ between cache and dram");
    index_out_a: assert property (@(posedge clk_i) disable iff (reset_i)
        req_valid_i |=> line_index_o == $past(addr_index))
        else $error("line index not from address");
    tag_exact_a: assert property (@(posedge clk_i) disable iff (reset_i)
        hit |-> tag_rdata_i == req_addr_i[23:18])
        else $error("hit with tag mismatch");
    hit_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
        hit_o |-> $past(tag_rdata_i) == $past(addr_tag))
        else $error("hit reported with tag mismatch");

endmodule

/* bench/tag_sram_model.sv */
// external tag sram model: read follows the request index, write during the strobe
// assumes index and tag widths from the cache policy package
`timescale 1ns/1ps
module tag_sram_model (
    input  wire logic                                  clk_i,
    input  wire logic [cache_policy_pkg::INDEX_W-1:0]  rd_index_i,
    output logic      [cache_policy_pkg::TAG_W-1:0]    rdata_o,
    input  wire logic                                  wr_i,
    input  wire logic [cache_policy_pkg::INDEX_W-1:0]  wr_index_i,
    input  wire logic [cache_policy_pkg::TAG_W-1:0]    wdata_i
);
    logic [cache_policy_pkg::TAG_W-1:0] mem [0:65535];
    bit                                 vld [0:65535];
    // unwritten entries return garbage after power-up
    assign rdata_o = vld[rd_index_i] ? mem[rd_index_i] : ~rd_index_i[5:0];
    always @(negedge clk_i) begin
        if (wr_i) begin
            mem[wr_index_i] <= wdata_i;
            vld[wr_index_i] <= 1'b1;
        end
    end
endmodule

/* bench/tb_cache_policy.sv */
// bench for the cache policy controller: register access and per-cycle decisions
// assumes the tag sram model in place of the external tag memory
`timescale 1ns/1ps
module tb_cache_policy;
    logic        clk_i = 0, reset_i = 1, req_valid_i = 0, req_mem_i = 0, req_write_i = 0;
    logic        reg_wr_i = 0, reg_rd_i = 0, tag_wr_o, cache_rd_o, dram_rd_o, hit_o, forced_miss_o;
    logic [2:0]  req_master_i = 0;
    logic [31:0] req_addr_i = 0;
    logic [3:0]  req_be_i = 0, cache_wr_o, dram_wr_o;
    logic [11:0] reg_addr_i = 0;
    logic [7:0]  reg_wdata_i = 0, reg_rdata_o;
    logic [5:0]  tag_rdata_i, tag_wdata_o;
    logic [15:0] line_index_o;
    logic [7:0]  rd_data;
    int          n_errors = 0, checks_done = 0, cycles = 0;
    localparam logic [31:0] ADDR_A = 32'h0004_0010, ADDR_B = 32'h000c_0010, ADDR_C = 32'h0080_0010;
    localparam logic [2:0]  CPU = 3'h1, DMA = 3'h2, CHN = 3'h4;

    cache_policy u_dut (.clk_i, .reset_i, .req_valid_i, .req_master_i, .req_mem_i, .req_write_i, .req_addr_i,
        .req_be_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .tag_rdata_i, .line_index_o,
        .tag_wdata_o, .tag_wr_o, .cache_wr_o, .cache_rd_o, .dram_rd_o, .dram_wr_o, .hit_o, .forced_miss_o);
    tag_sram_model u_tags (.clk_i, .rd_index_i(req_addr_i[17:2]), .rdata_o(tag_rdata_i), .wr_i(tag_wr_o),
        .wr_index_i(line_index_o), .wdata_i(tag_wdata_o));

    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 500) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // one access, then one idle cycle so strobes never toggle twice in a step
    task automatic reg_acc(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        reg_wr_i = wr;
        reg_rd_i = !wr;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        q = reg_rdata_o;
        reg_wr_i = 0;
        reg_rd_i = 0;
        @(negedge clk_i);
    endtask
    // expect/mask order: hit, cache read, dram read, tag write, cache lanes, dram lanes
    task automatic req(input logic [2:0] m, input logic mem, input logic wr, input logic [31:0] a,
                       input logic [3:0] be, input logic [11:0] exp, input logic [11:0] mask);
        req_valid_i = 1;
        req_master_i = m;
        req_mem_i = mem;
        req_write_i = wr;
        req_addr_i = a;
        req_be_i = be;
        @(negedge clk_i);
        req_valid_i = 0;
        check("decision", {hit_o, cache_rd_o, dram_rd_o, tag_wr_o, cache_wr_o, dram_wr_o} & mask, exp);
        @(negedge clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk_i);
        reset_i = 0;
        check("forced_miss", forced_miss_o, 1);
        reg_acc(0, 12'h180, 8'h00, rd_data);
        check("mode", rd_data, 8'h00);
        reg_acc(1, 12'h185, 8'h10, rd_data);
        reg_acc(0, 12'h185, 8'h00, rd_data);
        check("window1", rd_data, 8'h10);
        reg_acc(0, 12'h181, 8'h00, rd_data);
        check("unmapped", rd_data, 8'h00);
        req(CPU, 1, 0, ADDR_A, 4'hf, 12'h3f0, 12'hfff);
        check("index", line_index_o, 16'h0004);
        check("tag", tag_wdata_o, 6'h01);
        req(CPU, 1, 1, ADDR_A, 4'hf, 12'h00f, 12'h7ff);
        reg_acc(1, 12'h180, 8'h01, rd_data);
        reg_acc(0, 12'h180, 8'h00, rd_data);
        check("mode", rd_data, 8'h01);
        check("forced_miss", forced_miss_o, 0);
        req(CPU, 1, 0, ADDR_A, 4'hf, 12'hc00, 12'hfff);
        req(CPU, 1, 1, ADDR_A, 4'h3, 12'h833, 12'hfff);
        req(DMA, 1, 0, ADDR_A, 4'hf, 12'hc00, 12'hfff);
        req(DMA, 1, 0, ADDR_B, 4'hf, 12'h200, 12'hfff);
        req(DMA, 1, 1, ADDR_B, 4'hf, 12'h00f, 12'hfff);
        req(CHN, 1, 0, ADDR_A, 4'hf, 12'h200, 12'h7ff);
        req(CHN, 1, 1, ADDR_A, 4'hc, 12'h8cc, 12'hfff);
        req(CPU, 1, 0, ADDR_B, 4'hf, 12'h3f0, 12'hfff);
        check("tag", tag_wdata_o, 6'h03);
        req(CPU, 1, 0, 32'h0100_0010, 4'hf, 12'h3f0, 12'hfff);
        req(CPU, 0, 0, ADDR_B, 4'hf, 12'h000, 12'hfff);
        req(CPU, 1, 0, ADDR_C, 4'hf, 12'h200, 12'hfff);
        stop_test();
    end
endmodule
